// ---- rtl/ccp_pair.sv ----
`default_nettype none

module ccp_pair #(
	parameter int unsigned ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// Time bases from the timers and the converter enable
	input  wire logic [15:0]       timer_one_count,
	input  wire logic [7:0]        timer_two_count,
	input  wire logic              timer_two_match,
	input  wire logic              adc_enabled,
	// Pins and events
	input  wire logic [1:0]        unit_pin,
	output logic [1:0]             unit_pin_out,
	output logic [1:0]             unit_event_flag,
	output logic                   timer_one_reset,
	output logic                   adc_start
);

	ccp_pkg::top_state_t  s_q;
	ccp_pkg::top_state_t  s_d;
	ccp_pkg::unit_state_t u1;
	ccp_pkg::unit_state_t u2;
	logic                 accept;
	logic                 wr_any;
	logic [7:0]           wb;

	// ----------------------------------------------------------------
	// Write strobes seen by the units
	// ----------------------------------------------------------------
	assign wr_any = s_q.wr_pend;
	assign wb     = hwdata[7:0];

	// ----------------------------------------------------------------
	// Units (both see the same timer-two match)
	// ----------------------------------------------------------------
	ccp_unit unit_one (
		.hclk            (hclk),
		.hresetn         (hresetn),
		.cfg             (s_q.ctrl_one),
		.wr_lo           (wr_any && s_q.idx == ccp_pkg::IDX_VAL1_LOW),
		.wr_hi           (wr_any && s_q.idx == ccp_pkg::IDX_VAL1_HIGH),
		.wdata           (wb),
		.pin_level       (s_q.sync2[0]),
		.timer_one_count (timer_one_count),
		.timer_two_count (timer_two_count),
		.timer_two_match (timer_two_match),
		.st              (u1)
	);

	ccp_unit unit_two (
		.hclk            (hclk),
		.hresetn         (hresetn),
		.cfg             (s_q.ctrl_two),
		.wr_lo           (wr_any && s_q.idx == ccp_pkg::IDX_VAL2_LOW),
		.wr_hi           (wr_any && s_q.idx == ccp_pkg::IDX_VAL2_HIGH),
		.wdata           (wb),
		.pin_level       (s_q.sync2[1]),
		.timer_one_count (timer_one_count),
		.timer_two_count (timer_two_count),
		.timer_two_match (timer_two_match),
		.st              (u2)
	);

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	function automatic logic [7:0] read_byte(input logic [5:0] idx,
		input ccp_pkg::top_state_t s, input logic [15:0] v1, input logic [15:0] v2);
		logic [7:0] r;
		r = 8'h00;
		unique case (idx)
			ccp_pkg::IDX_FLAG_ONE:  r[ccp_pkg::FLAG_ONE_BIT] = s.flag_one;
			ccp_pkg::IDX_FLAG_TWO:  r[ccp_pkg::FLAG_TWO_BIT] = s.flag_two;
			ccp_pkg::IDX_VAL1_LOW:  r = v1[7:0];
			ccp_pkg::IDX_VAL1_HIGH: r = v1[15:8];
			ccp_pkg::IDX_CTRL_ONE:  r = {2'h0, s.ctrl_one};
			ccp_pkg::IDX_VAL2_LOW:  r = v2[7:0];
			ccp_pkg::IDX_VAL2_HIGH: r = v2[15:8];
			ccp_pkg::IDX_CTRL_TWO:  r = {2'h0, s.ctrl_two};
			default:                r = 8'h00;
		endcase
		return r;
	endfunction : read_byte

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d    = s_q;
		accept = hsel && hready && htrans[1];
		// Pin synchronisers; first stage feeds only the second
		s_d.sync1 = unit_pin;
		s_d.sync2 = s_q.sync1;
		// Data phase of a write
		if (s_q.wr_pend) begin
			unique case (s_q.idx)
				ccp_pkg::IDX_CTRL_ONE: s_d.ctrl_one = ccp_pkg::unit_cfg_t'(wb[5:0]);
				ccp_pkg::IDX_CTRL_TWO: s_d.ctrl_two = ccp_pkg::unit_cfg_t'(wb[5:0]);
				ccp_pkg::IDX_FLAG_ONE: s_d.flag_one = wb[ccp_pkg::FLAG_ONE_BIT];
				ccp_pkg::IDX_FLAG_TWO: s_d.flag_two = wb[ccp_pkg::FLAG_TWO_BIT];
				default: ;
			endcase
		end
		// Events set the flags and win over a clear
		if (u1.evt) begin
			s_d.flag_one = 1'b1;
		end
		if (u2.evt) begin
			s_d.flag_two = 1'b1;
		end
		// Special event trigger outputs
		s_d.t1_reset  = u1.trig | u2.trig;
		s_d.adc_start = u2.trig & adc_enabled;
		// Reads take one wait state so the data reflect a prior write
		s_d.resp = 1'b0;
		if (s_q.rd_pend) begin
			s_d.rdata = {24'h000000, read_byte(s_q.idx, s_q, u1.value, u2.value)};
			s_d.ready = 1'b1;
		end
		s_d.wr_pend = accept && hwrite;
		s_d.rd_pend = accept && !hwrite;
		if (accept) begin
			s_d.idx = haddr[7:2];
			if (!hwrite) begin
				s_d.ready = 1'b0;
			end
		end
	end

	// Register the state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q          <= '0;
			s_q.ready    <= 1'b1;
			s_q.ctrl_one <= ccp_pkg::unit_cfg_t'(ccp_pkg::CTRL_RST);
			s_q.ctrl_two <= ccp_pkg::unit_cfg_t'(ccp_pkg::CTRL_RST);
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hreadyout       = s_q.ready;
	assign hresp           = s_q.resp;
	assign hrdata          = s_q.rdata;
	assign unit_pin_out    = {u2.pin_out, u1.pin_out};
	assign unit_event_flag = {s_q.flag_two, s_q.flag_one};
	assign timer_one_reset = s_q.t1_reset;
	assign adc_start       = s_q.adc_start;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_flag_set_wins;
		@(posedge hclk) disable iff (!hresetn)
		u1.evt |=> s_q.flag_one;
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag lost");

	property p_flag_holds;
		@(posedge hclk) disable iff (!hresetn)
		s_q.flag_one && !(s_q.wr_pend && s_q.idx == ccp_pkg::IDX_FLAG_ONE) |=> s_q.flag_one;
	endproperty
	a_flag_holds: assert property (p_flag_holds) else $error("flag self cleared");

	property p_ctrl_top_zero;
		@(posedge hclk) disable iff (!hresetn)
		s_q.rd_pend && s_q.idx == ccp_pkg::IDX_CTRL_ONE |=> hreadyout && hrdata[7:6] == 2'h0;
	endproperty
	a_ctrl_top_zero: assert property (p_ctrl_top_zero) else $error("ctrl 7:6 not zero");

	property p_adc_start;
		@(posedge hclk) disable iff (!hresetn)
		u2.trig && adc_enabled |=> adc_start && timer_one_reset;
	endproperty
	a_adc_start: assert property (p_adc_start) else $error("converter not started");

	property p_trig_reset;
		@(posedge hclk) disable iff (!hresetn)
		u1.trig || u2.trig |=> timer_one_reset;
	endproperty
	a_trig_reset: assert property (p_trig_reset) else $error("timer reset missed");

	property p_adc_quiet;
		@(posedge hclk) disable iff (!hresetn)
		!(u2.trig && adc_enabled) |=> !adc_start;
	endproperty
	a_adc_quiet: assert property (p_adc_quiet) else $error("stray converter start");

	// Unit two flag is sticky like unit one
	property p_flag_two_set;
		@(posedge hclk) disable iff (!hresetn)
		u2.evt |=> s_q.flag_two;
	endproperty
	a_flag_two_set: assert property (p_flag_two_set) else $error("flag two lost");

	property p_flag_two_holds;
		@(posedge hclk) disable iff (!hresetn)
		s_q.flag_two && !(s_q.wr_pend && s_q.idx == ccp_pkg::IDX_FLAG_TWO)
			|=> s_q.flag_two;
	endproperty
	a_flag_two_holds: assert property (p_flag_two_holds) else $error("flag two dropped");

	// A software zero clears a flag when no event competes
	property p_flag_one_clear;
		@(posedge hclk) disable iff (!hresetn)
		s_q.wr_pend && s_q.idx == ccp_pkg::IDX_FLAG_ONE && !u1.evt
			&& !wb[ccp_pkg::FLAG_ONE_BIT] |=> !s_q.flag_one;
	endproperty
	a_flag_one_clear: assert property (p_flag_one_clear) else $error("flag one kept");

	property p_flag_two_clear;
		@(posedge hclk) disable iff (!hresetn)
		s_q.wr_pend && s_q.idx == ccp_pkg::IDX_FLAG_TWO && !u2.evt
			&& !wb[ccp_pkg::FLAG_TWO_BIT] |=> !s_q.flag_two;
	endproperty
	a_flag_two_clear: assert property (p_flag_two_clear) else $error("flag two kept");

	// Control writes land at the end of the data phase
	property p_ctrl_one_write;
		@(posedge hclk) disable iff (!hresetn)
		s_q.wr_pend && s_q.idx == ccp_pkg::IDX_CTRL_ONE
			|=> s_q.ctrl_one == ccp_pkg::unit_cfg_t'($past(hwdata[5:0]));
	endproperty
	a_ctrl_one_write: assert property (p_ctrl_one_write) else $error("ctrl one lost");

	property p_ctrl_two_write;
		@(posedge hclk) disable iff (!hresetn)
		s_q.wr_pend && s_q.idx == ccp_pkg::IDX_CTRL_TWO
			|=> s_q.ctrl_two == ccp_pkg::unit_cfg_t'($past(hwdata[5:0]));
	endproperty
	a_ctrl_two_write: assert property (p_ctrl_two_write) else $error("ctrl two lost");

	// Read returns: the wait cycle loads what the register held
	sequence s_reads(logic [5:0] i);
		s_q.rd_pend && s_q.idx == i;
	endsequence

	property p_ctrl_two_zero;
		@(posedge hclk) disable iff (!hresetn)
		s_reads(ccp_pkg::IDX_CTRL_TWO) |=> hreadyout && hrdata[7:6] == 2'h0;
	endproperty
	a_ctrl_two_zero: assert property (p_ctrl_two_zero) else $error("ctrl two bad");

	property p_flag_one_read;
		@(posedge hclk) disable iff (!hresetn)
		s_reads(ccp_pkg::IDX_FLAG_ONE)
			|=> hrdata[ccp_pkg::FLAG_ONE_BIT] == $past(s_q.flag_one);
	endproperty
	a_flag_one_read: assert property (p_flag_one_read) else $error("flag one read");

	property p_flag_two_read;
		@(posedge hclk) disable iff (!hresetn)
		s_reads(ccp_pkg::IDX_FLAG_TWO)
			|=> hrdata[ccp_pkg::FLAG_TWO_BIT] == $past(s_q.flag_two);
	endproperty
	a_flag_two_read: assert property (p_flag_two_read) else $error("flag two read");

	property p_val1_low_read;
		@(posedge hclk) disable iff (!hresetn)
		s_reads(ccp_pkg::IDX_VAL1_LOW) |=> hrdata[7:0] == $past(u1.value[7:0]);
	endproperty
	a_val1_low_read: assert property (p_val1_low_read) else $error("value one low");

	property p_val1_high_read;
		@(posedge hclk) disable iff (!hresetn)
		s_reads(ccp_pkg::IDX_VAL1_HIGH) |=> hrdata[7:0] == $past(u1.value[15:8]);
	endproperty
	a_val1_high_read: assert property (p_val1_high_read) else $error("value one high");

	property p_val2_high_read;
		@(posedge hclk) disable iff (!hresetn)
		s_reads(ccp_pkg::IDX_VAL2_HIGH) |=> hrdata[7:0] == $past(u2.value[15:8]);
	endproperty
	a_val2_high_read: assert property (p_val2_high_read) else $error("value two high");

endmodule : ccp_pair

`default_nettype wire

// ---- rtl/ccp_pkg.sv ----
`default_nettype none

package ccp_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_FLAG_ONE  = 6'h0c;
	localparam logic [5:0] IDX_FLAG_TWO  = 6'h0d;
	localparam logic [5:0] IDX_VAL1_LOW  = 6'h15;
	localparam logic [5:0] IDX_VAL1_HIGH = 6'h16;
	localparam logic [5:0] IDX_CTRL_ONE  = 6'h17;
	localparam logic [5:0] IDX_VAL2_LOW  = 6'h1b;
	localparam logic [5:0] IDX_VAL2_HIGH = 6'h1c;
	localparam logic [5:0] IDX_CTRL_TWO  = 6'h1d;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned FLAG_ONE_BIT = 2;
	localparam int unsigned FLAG_TWO_BIT = 0;
	localparam logic [5:0]  CTRL_RST     = 6'h00;
	localparam logic [15:0] VALUE_RST    = 16'h0000;

	// ----------------------------------------------------------------
	// Mode codes and prescaler limits
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_OFF       = 4'h0;
	localparam logic [1:0] GRP_CAPTURE    = 2'h1;
	localparam logic [1:0] GRP_COMPARE    = 2'h2;
	localparam logic [1:0] GRP_PWM        = 2'h3;
	localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
	localparam logic [3:0] MODE_CAP_4TH   = 4'h6;
	localparam logic [3:0] MODE_CAP_16TH  = 4'h7;
	localparam logic [3:0] MODE_CMP_HIGH  = 4'h8;
	localparam logic [3:0] MODE_CMP_LOW   = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT  = 4'ha;
	localparam logic [3:0] MODE_CMP_TRIG  = 4'hb;
	localparam logic [3:0] PRESC_4_LAST   = 4'h3;
	localparam logic [3:0] PRESC_16_LAST  = 4'hf;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] duty_low;
		logic [3:0] unit_mode_field;
	} unit_cfg_t;

	typedef struct packed {
		logic        pin_prev;
		logic        match_prev;
		logic [3:0]  presc;
		logic [1:0]  qphase;
		logic [1:0]  duty_lo2;
		logic [15:0] value;
		logic        pin_out;
		logic        evt;
		logic        trig;
	} unit_state_t;

	typedef struct packed {
		logic [1:0]  sync1;
		logic [1:0]  sync2;
		unit_cfg_t   ctrl_one;
		unit_cfg_t   ctrl_two;
		logic        flag_one;
		logic        flag_two;
		logic        wr_pend;
		logic        rd_pend;
		logic [5:0]  idx;
		logic        ready;
		logic        resp;
		logic [31:0] rdata;
		logic        t1_reset;
		logic        adc_start;
	} top_state_t;

endpackage : ccp_pkg

`default_nettype wire

// ---- rtl/ccp_unit.sv ----
`default_nettype none

module ccp_unit (
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// Software side
	input  wire ccp_pkg::unit_cfg_t cfg,
	input  wire logic              wr_lo,
	input  wire logic              wr_hi,
	input  wire logic [7:0]        wdata,
	// Pin level, already synchronised
	input  wire logic              pin_level,
	// Shared time bases
	input  wire logic [15:0]       timer_one_count,
	input  wire logic [7:0]        timer_two_count,
	input  wire logic              timer_two_match,
	// Results
	output var  ccp_pkg::unit_state_t st
);

	ccp_pkg::unit_state_t s_d;
	logic [3:0]           mode;
	logic                 rise;
	logic                 fall;
	logic                 hit;
	logic                 match;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d      = st;
		mode     = cfg.unit_mode_field;
		rise     = pin_level & ~st.pin_prev;
		fall     = ~pin_level & st.pin_prev;
		hit      = 1'b0;
		match    = (timer_one_count == st.value);
		s_d.evt  = 1'b0;
		s_d.trig = 1'b0;
		s_d.pin_prev   = pin_level;
		s_d.match_prev = 1'b0;
		if (wr_lo) begin
			s_d.value[7:0] = wdata;
		end
		if (wr_hi && mode[3:2] != ccp_pkg::GRP_PWM) begin
			s_d.value[15:8] = wdata;
		end
		unique case (mode[3:2])
			ccp_pkg::GRP_CAPTURE: begin
				// Counter is kept across capture settings
				unique case (mode)
					ccp_pkg::MODE_CAP_FALL: hit = fall;
					ccp_pkg::MODE_CAP_RISE: hit = rise;
					default: begin
						if (rise) begin
							if (st.presc >= ((mode == ccp_pkg::MODE_CAP_4TH) ?
								ccp_pkg::PRESC_4_LAST : ccp_pkg::PRESC_16_LAST)) begin
								hit       = 1'b1;
								s_d.presc = 4'h0;
							end else begin
								s_d.presc = st.presc + 4'h1;
							end
						end
					end
				endcase
				if (hit) begin
					s_d.value = timer_one_count;
					s_d.evt   = 1'b1;
				end
			end
			ccp_pkg::GRP_COMPARE: begin
				s_d.presc      = 4'h0;
				s_d.match_prev = match;
				if (match && !st.match_prev) begin
					s_d.evt = 1'b1;
					unique case (mode[1:0])
						2'h0: s_d.pin_out = 1'b1;
						2'h1: s_d.pin_out = 1'b0;
						2'h2: s_d.pin_out = st.pin_out;
						2'h3: s_d.trig    = 1'b1;
					endcase
				end
			end
			ccp_pkg::GRP_PWM: begin
				s_d.presc  = 4'h0;
				s_d.qphase = st.qphase + 2'h1;
				if (timer_two_match) begin
					// Period end latches duty and sets pin unless 0 %
					s_d.value[15:8] = st.value[7:0];
					s_d.duty_lo2    = cfg.duty_low;
					s_d.qphase      = 2'h0;
					s_d.pin_out     = ({st.value[7:0], cfg.duty_low} != 10'h000);
				end else if ({st.value[15:8], st.duty_lo2} ==
					{timer_two_count, st.qphase}) begin
					s_d.pin_out = 1'b0;
				end
			end
			default: begin
				// Off: prescaler, phase and pin reset, value kept
				s_d.presc   = 4'h0;
				s_d.qphase  = 2'h0;
				s_d.pin_out = 1'b0;
			end
		endcase
	end

	// Register the state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st       <= '0;
			st.value <= ccp_pkg::VALUE_RST;
		end else begin
			st <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_rise_in(logic [3:0] m);
		cfg.unit_mode_field == m && pin_level && !st.pin_prev;
	endsequence

	property p_rise_capture;
		@(posedge hclk) disable iff (!hresetn)
		s_rise_in(ccp_pkg::MODE_CAP_RISE) |=>
			st.evt && st.value == $past(timer_one_count);
	endproperty
	a_rise_capture: assert property (p_rise_capture) else $error("rise capture missed");

	property p_fourth_edge;
		@(posedge hclk) disable iff (!hresetn)
		s_rise_in(ccp_pkg::MODE_CAP_4TH) and st.presc == 4'h3 |=> st.evt && st.presc == 4'h0;
	endproperty
	a_fourth_edge: assert property (p_fourth_edge) else $error("4th edge missed");

	property p_presc_clear;
		@(posedge hclk) disable iff (!hresetn)
		cfg.unit_mode_field[3:2] != ccp_pkg::GRP_CAPTURE |=> st.presc == 4'h0;
	endproperty
	a_presc_clear: assert property (p_presc_clear) else $error("prescaler not held");

	property p_soft_pin;
		@(posedge hclk) disable iff (!hresetn)
		(cfg.unit_mode_field == ccp_pkg::MODE_CMP_SOFT) [*2] |-> $stable(st.pin_out);
	endproperty
	a_soft_pin: assert property (p_soft_pin) else $error("pin moved in soft mode");

	property p_match_event;
		@(posedge hclk) disable iff (!hresetn)
		cfg.unit_mode_field == ccp_pkg::MODE_CMP_TRIG && match && !st.match_prev
			|=> st.evt && st.trig ##1 !st.trig;
	endproperty
	a_match_event: assert property (p_match_event) else $error("compare trigger wrong");

	property p_duty_latch;
		@(posedge hclk) disable iff (!hresetn)
		cfg.unit_mode_field[3:2] == ccp_pkg::GRP_PWM && timer_two_match
			|=> st.value[15:8] == $past(st.value[7:0]);
	endproperty
	a_duty_latch: assert property (p_duty_latch) else $error("duty not latched");

endmodule : ccp_unit

`default_nettype wire

// ---- verif/ccp_mode_control_and_capture_tb.sv ----
`default_nettype none

module ccp_mode_control_and_capture_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Signals and tables
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] mode;
		logic [4:0] pulses;
		logic       flag;
	} row_t;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [7:0]  haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [15:0] t1;
	logic [7:0]  t2;
	logic        t2m;
	logic        adc_enabled;
	logic [1:0]  pins;
	logic [1:0]  pin_out;
	logic [1:0]  evf;
	logic        t1_rst;
	logic        adc_go;
	logic        rdy_s;
	logic [31:0] rd_s;
	logic [7:0]  rv;
	logic [15:0] ev;
	logic        trig_seen;
	logic        adc_seen;
	int          fails;
	int          samples_checked;
	row_t        rows[6] = '{'{4'h4, 5'h01, 1'b1}, '{4'h5, 5'h01, 1'b1}, '{4'h6, 5'h03, 1'b0},
		'{4'h7, 5'h0f, 1'b0}, '{4'h6, 5'h04, 1'b1}, '{4'h7, 5'h10, 1'b1}};
	logic [5:0]  ridx[5] = '{ccp_pkg::IDX_CTRL_ONE, ccp_pkg::IDX_CTRL_TWO,
		ccp_pkg::IDX_VAL1_HIGH, ccp_pkg::IDX_FLAG_ONE, 6'h3f};
	logic [3:0]  cmode[3] = '{ccp_pkg::MODE_CMP_HIGH, ccp_pkg::MODE_CMP_SOFT, ccp_pkg::MODE_CMP_LOW};
	logic        cpin[3] = '{1'b1, 1'b1, 1'b0};

	// ----------------------------------------------------------------
	// Design, pin source and clock
	// ----------------------------------------------------------------
	ccp_pair dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_one_count(t1),
		.timer_two_count(t2), .timer_two_match(t2m), .adc_enabled(adc_enabled),
		.unit_pin(pins), .unit_pin_out(pin_out), .unit_event_flag(evf),
		.timer_one_reset(t1_rst), .adc_start(adc_go)
	);

	pin_source src (.hclk(hclk), .pins(pins));

	// Free running clock
	always #50 hclk = ~hclk;

	// Bus answer sampled mid-cycle, it stands until the next rising edge
	always @(negedge hclk) begin
		rdy_s = hreadyout;
		rd_s = hrdata;
	end

	// One-cycle trigger pulses are kept as sticky marks
	always @(posedge hclk) begin
		if (t1_rst === 1'b1) trig_seen <= 1'b1;
		if (adc_go === 1'b1) adc_seen <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic tend(input string s);
		$display("%0t: test %s finished", $time, s);
	endtask : tend

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	// Single word transfer: address phase, then data phase, both held until ready
	task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {i, 2'b00};
		do begin @(posedge hclk); n++; end while (rdy_s !== 1'b1 && n < 20);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do begin @(posedge hclk); n++; end while (rdy_s !== 1'b1 && n < 40);
		rv = rd_s[7:0];
		if (n >= 20) begin
			fails++;
			$display("MISMATCH at %0t: bus wait ran out", $time);
			wrap_up();
		end
	endtask : bus

	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
	endtask : wr

	task automatic rd(input logic [5:0] i);
		bus(1'b0, i, 8'h00);
	endtask : rd

	// Off, new mode in one write, then clear the flag a mode change may set
	task automatic cap(input logic [5:0] c, input logic [3:0] m, input logic [5:0] f);
		wr(c, 8'h00);
		wr(c, {4'h0, m});
		wr(f, 8'h00);
	endtask : cap

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 8'h00;
		hwdata = 32'h00000000;
		t1 = 16'h0000;
		t2 = 8'h05;
		t2m = 1'b0;
		adc_enabled = 1'b0;
		trig_seen = 1'b0;
		adc_seen = 1'b0;
		ev = 16'h0000;
		fails = 0;
		samples_checked = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values, an unmapped word stays zero
		wr(6'h3f, 8'hff);
		foreach (ridx[k]) begin
			rd(ridx[k]);
			check(rv, 8'h00);
		end
		wr(ccp_pkg::IDX_CTRL_ONE, 8'hff);
		rd(ccp_pkg::IDX_CTRL_ONE);
		check(rv, 8'h3f);
		tend("reset and control bits");
		// Capture table, counter restarts from off each row
		foreach (rows[k]) begin
			cap(ccp_pkg::IDX_CTRL_ONE, rows[k].mode, ccp_pkg::IDX_FLAG_ONE);
			t1 <= 16'h1000 + 16'(k);
			src.pulse(0, int'(rows[k].pulses), 2);
			repeat (4) @(posedge hclk);
			rd(ccp_pkg::IDX_FLAG_ONE);
			check({7'h00, rv[2]}, {7'h00, rows[k].flag});
			if (rows[k].flag) ev = 16'h1000 + 16'(k);
			rd(ccp_pkg::IDX_VAL1_LOW);
			check(rv, ev[7:0]);
			rd(ccp_pkg::IDX_VAL1_HIGH);
			check(rv, ev[15:8]);
			tend("capture row");
		end
		// Back-to-back captures overwrite, flag stays until cleared
		cap(ccp_pkg::IDX_CTRL_ONE, ccp_pkg::MODE_CAP_RISE, ccp_pkg::IDX_FLAG_ONE);
		t1 <= 16'haaaa;
		src.pulse(0, 1, 2);
		t1 <= 16'h5a3c;
		src.pulse(0, 1, 3);
		repeat (30) @(posedge hclk);
		check({6'h00, evf}, 8'h01);
		rd(ccp_pkg::IDX_VAL1_LOW);
		check(rv, 8'h3c);
		rd(ccp_pkg::IDX_VAL1_HIGH);
		check(rv, 8'h5a);
		wr(ccp_pkg::IDX_FLAG_ONE, 8'h00);
		rd(ccp_pkg::IDX_FLAG_ONE);
		check({7'h00, rv[2]}, 8'h00);
		wr(ccp_pkg::IDX_CTRL_ONE, 8'h00);
		rd(ccp_pkg::IDX_VAL1_LOW);
		check(rv, 8'h3c);
		tend("overwrite and off");
		// Direct switch of prescale keeps the partial count
		cap(ccp_pkg::IDX_CTRL_ONE, ccp_pkg::MODE_CAP_4TH, ccp_pkg::IDX_FLAG_ONE);
		src.pulse(0, 2, 2);
		wr(ccp_pkg::IDX_CTRL_ONE, {4'h0, ccp_pkg::MODE_CAP_16TH});
		wr(ccp_pkg::IDX_FLAG_ONE, 8'h00);
		src.pulse(0, 13, 2);
		repeat (4) @(posedge hclk);
		rd(ccp_pkg::IDX_FLAG_ONE);
		check({7'h00, rv[2]}, 8'h00);
		src.pulse(0, 1, 2);
		repeat (4) @(posedge hclk);
		rd(ccp_pkg::IDX_FLAG_ONE);
		check({7'h00, rv[2]}, 8'h01);
		tend("prescale switch");
		// Unit two on a falling edge
		cap(ccp_pkg::IDX_CTRL_TWO, ccp_pkg::MODE_CAP_FALL, ccp_pkg::IDX_FLAG_TWO);
		t1 <= 16'hbeef;
		src.pulse(1, 1, 2);
		repeat (4) @(posedge hclk);
		rd(ccp_pkg::IDX_FLAG_TWO);
		check({7'h00, rv[0]}, 8'h01);
		rd(ccp_pkg::IDX_VAL2_HIGH);
		check(rv, 8'hbe);
		tend("unit two capture");
		// Compare actions on unit one
		wr(ccp_pkg::IDX_CTRL_TWO, 8'h00);
		wr(ccp_pkg::IDX_CTRL_ONE, 8'h00);
		t1 <= 16'h0000;
		wr(ccp_pkg::IDX_VAL1_LOW, 8'h00);
		wr(ccp_pkg::IDX_VAL1_HIGH, 8'h01);
		foreach (cmode[k]) begin
			wr(ccp_pkg::IDX_CTRL_ONE, {4'h0, cmode[k]});
			wr(ccp_pkg::IDX_FLAG_ONE, 8'h00);
			t1 <= 16'h0100;
			repeat (3) @(posedge hclk);
			t1 <= 16'h0000;
			repeat (3) @(posedge hclk);
			check({7'h00, pin_out[0]}, {7'h00, cpin[k]});
			rd(ccp_pkg::IDX_FLAG_ONE);
			check({7'h00, rv[2]}, 8'h01);
		end
		tend("compare actions");
		// Special trigger of unit two with the converter enabled
		check({6'h00, trig_seen, adc_seen}, 8'h00);
		adc_enabled <= 1'b1;
		wr(ccp_pkg::IDX_CTRL_ONE, 8'h00);
		wr(ccp_pkg::IDX_CTRL_TWO, 8'h00);
		wr(ccp_pkg::IDX_VAL2_LOW, 8'h00);
		wr(ccp_pkg::IDX_VAL2_HIGH, 8'h02);
		wr(ccp_pkg::IDX_CTRL_TWO, {4'h0, ccp_pkg::MODE_CMP_TRIG});
		t1 <= 16'h0200;
		repeat (4) @(posedge hclk);
		t1 <= 16'h0000;
		repeat (2) @(posedge hclk);
		check({6'h00, trig_seen, adc_seen}, 8'h03);
		tend("special trigger");
		// Both units in PWM share one period end and duty latch
		wr(ccp_pkg::IDX_CTRL_TWO, 8'h00);
		wr(ccp_pkg::IDX_VAL1_LOW, 8'h01);
		wr(ccp_pkg::IDX_VAL2_LOW, 8'h01);
		wr(ccp_pkg::IDX_CTRL_ONE, 8'h1c);
		wr(ccp_pkg::IDX_CTRL_TWO, 8'h1c);
		t2m <= 1'b1;
		@(posedge hclk);
		t2m <= 1'b0;
		repeat (3) @(posedge hclk);
		check({6'h00, pin_out}, 8'h03);
		rd(ccp_pkg::IDX_VAL2_HIGH);
		check(rv, 8'h01);
		t2 <= 8'h01;
		repeat (6) @(posedge hclk);
		check({6'h00, pin_out}, 8'h00);
		tend("shared pwm");
		// Reset in mid-run clears flags, control and values
		check({6'h00, evf}, 8'h03);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		check({6'h00, evf}, 8'h00);
		rd(ccp_pkg::IDX_CTRL_ONE);
		check(rv, 8'h00);
		rd(ccp_pkg::IDX_VAL2_HIGH);
		check(rv, 8'h00);
		tend("reset in mid-run");
		wrap_up();
	end

endmodule : ccp_mode_control_and_capture_tb

`default_nettype wire

// ---- verif/pin_source.sv ----
`default_nettype none

// ----------------------------------------------------------------
// External signal source on the capture pins
// ----------------------------------------------------------------
module pin_source (
	// Clock
	input  wire logic       hclk,
	// Pin levels seen by the units
	output var  logic [1:0] pins
);
	timeunit 1ns;
	timeprecision 1ns;

	// Pins rest low and are always driven, the unit only reads them
	initial pins = 2'b00;

	// Whole pulses, each level held for hold cycles, stepped on hclk
	task automatic pulse(input int u, input int n, input int hold);
		repeat (n) begin
			pins[u] <= 1'b1;
			repeat (hold) @(posedge hclk);
			pins[u] <= 1'b0;
			repeat (hold) @(posedge hclk);
		end
	endtask : pulse

endmodule : pin_source

`default_nettype wire
